// ==== hdl/reset_init_sequencer.sv ====
// Purpose: power-on and pin reset sequencing, config pin latching
// Assumes: sys_clk_in is the bus sync clock; pins are asynchronous
// Notes:   reset pins are open drain, active low
`timescale 1ns/1ps
`include "reset_init_defines.svh"

// Summary of operation
// - drive resets 512 cycles, soft 16 later
// - config pin drive off with hard reset
// - config drive resumes a cycle after release
// - allow 100 us for PLL lock
// - DLL lock between 7680 and 122880 cycles
// - divider config selects bus sync period
// - system bus clock from PLL ratio
module reset_init_sequencer
  import reset_init_pkg::*;
#(
  parameter logic [16:0] DLL_MIN_CYC = `RIS_DLL_MIN_CYC,
  parameter logic [16:0] DLL_MAX_CYC = `RIS_DLL_MAX_CYC
) (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       srst_in,
  // power-on reset pin
  input  wire logic       power_on_reset_n_in,
  // hard reset pin, open drain
  input  wire logic       hard_reset_n_in,
  output logic            hard_reset_n_out,
  output logic            hard_reset_n_oe_out,
  // soft reset pin, open drain
  input  wire logic       soft_reset_n_in,
  output logic            soft_reset_n_out,
  output logic            soft_reset_n_oe_out,
  // power-on config pins, two-way
  input  wire logic [2:0] reset_source_cfg_in,
  output logic      [2:0] reset_source_cfg_out,
  input  wire logic       input_clock_div_cfg_in,
  output logic            input_clock_div_cfg_out,
  output logic            cfg_oe_out,
  // lock indicators
  input  wire logic       pll_lock_in,
  input  wire logic       dll_lock_in,
  // internal side
  output logic            internal_reset_out,
  output logic            lock_timeout_out
);

  localparam logic [16:0] PLL_CYC = 17'(`RIS_PLL_CYC);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [16:0] cnt_inc(input logic [16:0] c);
    cnt_inc = c + 17'd1;
  endfunction : cnt_inc

  function automatic logic [9:0] age_inc(input logic [9:0] a);
    age_inc = (a == `RIS_AGE_MAX) ? a : a + 10'd1;
  endfunction : age_inc

  function automatic logic [5:0] req_inc(input logic [5:0] r);
    req_inc = (r == `RIS_REQ_CYC) ? r : r + 6'd1;
  endfunction : req_inc

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [8:0] pins_s;
  logic       por_s;
  logic       hard_s;
  logic       soft_s;
  logic       pll_s;
  logic       dll_s;
  logic [2:0] rsrc_s;
  logic       div_s;

  pin_sync #(.WIDTH(9)) u_sync (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .rst_val_in (9'h00e),
    .async_in   ({reset_source_cfg_in, input_clock_div_cfg_in,
                  dll_lock_in, pll_lock_in, soft_reset_n_in,
                  hard_reset_n_in, power_on_reset_n_in}),
    .sync_out   (pins_s)
  );

  assign por_s  = pins_s[0];
  assign hard_s = pins_s[1];
  assign soft_s = pins_s[2];
  assign pll_s  = pins_s[3];
  assign dll_s  = pins_s[4];
  assign div_s  = pins_s[5];
  assign rsrc_s = pins_s[8:6];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  seq_reg_type q;
  seq_reg_type d;

  always_comb begin
    d = q;
    d.cnt = cnt_inc(q.cnt);
    // request lengths, only while the pin is not our own drive
    d.hreq = (!q.hard_oe && !hard_s) ? req_inc(q.hreq) : 6'd0;
    d.sreq = (!q.soft_oe && !soft_s) ? req_inc(q.sreq) : 6'd0;
    d.hard_age = q.hard_oe ? age_inc(q.hard_age) : 10'd0;
    d.soft_age = q.soft_oe ? age_inc(q.soft_age) : 10'd0;
    d.gap = q.hard_oe ? 5'd0 :
            (q.gap == `RIS_GAP_MAX) ? q.gap : q.gap + 5'd1;
    unique case (q.st)
      ST_POR: begin
        // config follows the pins and freezes at release
        d.rsrc = rsrc_s;
        d.div  = div_s;
        d.cnt  = 17'd0;
        if (por_s) begin
          d.st = ST_PLL;
        end
      end
      ST_PLL: begin
        if (pll_s) begin
          d.st  = ST_DLL;
          d.cnt = 17'd0;
        end else if (q.cnt == PLL_CYC - 17'd1) begin
          d.st       = ST_DLL;
          d.cnt      = 17'd0;
          d.lock_err = 1'b1;
        end
      end
      ST_DLL: begin
        // counted in sys_clk_in cycles, the bus sync clock
        if (dll_s && q.cnt >= DLL_MIN_CYC - 17'd1) begin
          d.st  = ST_HOLD;
          d.cnt = 17'd0;
        end else if (q.cnt == DLL_MAX_CYC - 17'd1) begin
          d.st       = ST_HOLD;
          d.cnt      = 17'd0;
          d.lock_err = 1'b1;
        end
      end
      ST_HOLD: begin
        if (q.cnt == `RIS_HOLD_CYC - 17'd1) begin
          d.st      = ST_HREL;
          d.cnt     = 17'd0;
          d.hard_oe = 1'b0;
        end
      end
      ST_HREL: begin
        d.cfg_oe = 1'b1;
        if (q.cnt == `RIS_GAP_CYC - 17'd1) begin
          d.st      = ST_RUN;
          d.soft_oe = 1'b0;
          d.int_rst = 1'b0;
        end
      end
      ST_RUN: begin
        if (q.sreq == `RIS_REQ_CYC) begin
          d.st      = ST_SOFT;
          d.cnt     = 17'd0;
          d.soft_oe = 1'b1;
        end
      end
      ST_SOFT: begin
        if (q.cnt == `RIS_HOLD_CYC - 17'd1) begin
          d.st      = ST_RUN;
          d.soft_oe = 1'b0;
        end
      end
      default: begin
        d.st = ST_POR;
      end
    endcase
    // external hard reset restarts the drive phase
    if ((q.st == ST_RUN || q.st == ST_SOFT) &&
        q.hreq == `RIS_REQ_CYC) begin
      d.st      = ST_HOLD;
      d.cnt     = 17'd0;
      d.hard_oe = 1'b1;
      d.soft_oe = 1'b1;
      d.cfg_oe  = 1'b0;
      d.int_rst = 1'b1;
    end
    if (!por_s) begin
      d.st      = ST_POR;
      d.hard_oe = 1'b1;
      d.soft_oe = 1'b1;
      d.cfg_oe  = 1'b0;
      d.int_rst = 1'b1;
      d.lock_err = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      q          <= '0;
      q.st       <= ST_POR;
      q.hard_oe  <= 1'b1;
      q.soft_oe  <= 1'b1;
      q.int_rst  <= 1'b1;
      q.rsrc     <= `RIS_RSRC_RST;
      q.div      <= `RIS_DIV_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hard_reset_n_out        = 1'b0;
  assign hard_reset_n_oe_out     = q.hard_oe;
  assign soft_reset_n_out        = 1'b0;
  assign soft_reset_n_oe_out     = q.soft_oe;
  assign reset_source_cfg_out    = q.rsrc;
  assign input_clock_div_cfg_out = q.div;
  assign cfg_oe_out              = q.cfg_oe;
  assign internal_reset_out      = q.int_rst;
  assign lock_timeout_out        = q.lock_err;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  hard_hold_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    $fell(q.hard_oe) |-> q.hard_age >= 10'd512)
    else $error("hard reset released too early");

  soft_hold_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    $fell(q.soft_oe) |-> q.soft_age >= 10'd512)
    else $error("soft reset released too early");

  soft_gap_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    $fell(q.soft_oe) |-> q.gap >= 5'd16)
    else $error("soft release too close to hard release");

  cfg_off_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    q.hard_oe |-> !q.cfg_oe)
    else $error("config pins driven during hard reset");

  cfg_on_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    $rose(q.cfg_oe) |-> !q.hard_oe && !$past(q.hard_oe))
    else $error("config drive resumed too early");

  cfg_latch_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    (q.st != ST_POR) ##1 (q.st != ST_POR) |-> $stable(q.rsrc))
    else $error("latched config changed after release");

  pll_wait_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    q.st == ST_PLL |-> q.cnt < PLL_CYC)
    else $error("pll wait exceeded");

  dll_min_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    (q.st == ST_DLL) ##1 (q.st == ST_HOLD) |->
      $past(q.cnt) >= DLL_MIN_CYC - 17'd1)
    else $error("dll accepted too early");

  req_len_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    (q.st == ST_RUN) ##1 (q.st == ST_SOFT) |-> $past(q.sreq) == 6'd32)
    else $error("soft request shorter than 32 cycles");

  int_rst_a: assert property (
    @(posedge sys_clk_in) disable iff (srst_in)
    !q.int_rst |-> (q.st == ST_RUN || q.st == ST_SOFT) && !q.hard_oe)
    else $error("internal reset released before sequence end");

endmodule : reset_init_sequencer

// ==== hdl/reset_init_defines.svh ====
// Purpose: constants of the reset initialization sequencer
// Assumes: sys_clk_in stands for the bus sync clock, 10 MHz
// Notes:   counts are in sys_clk_in cycles
`ifndef RESET_INIT_DEFINES_SVH
`define RESET_INIT_DEFINES_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define RIS_CLK_MHZ        10
`define RIS_PLL_LOCK_US    100
// longest time, rounded down
`define RIS_PLL_CYC        (`RIS_PLL_LOCK_US * `RIS_CLK_MHZ)
`define RIS_DLL_MIN_CYC    17'd7680
`define RIS_DLL_MAX_CYC    17'd122880
`define RIS_HOLD_CYC       17'd512
`define RIS_GAP_CYC        17'd16
`define RIS_REQ_CYC        6'd32

// ----------------------------------------------------------------
// reset values and counter limits
// ----------------------------------------------------------------
`define RIS_RSRC_RST       3'h0
`define RIS_DIV_RST        1'h0
`define RIS_AGE_MAX        10'h3ff
`define RIS_GAP_MAX        5'h1f

`endif

// ==== hdl/reset_init_pkg.sv ====
// Purpose: types of the reset initialization sequencer
// Assumes: nothing
// Notes:   one-hot state codes
package reset_init_pkg;

  typedef enum logic [6:0] {
    ST_POR  = 7'b0000001,
    ST_PLL  = 7'b0000010,
    ST_DLL  = 7'b0000100,
    ST_HOLD = 7'b0001000,
    ST_HREL = 7'b0010000,
    ST_RUN  = 7'b0100000,
    ST_SOFT = 7'b1000000
  } seq_state_type;

  typedef struct packed {
    seq_state_type st;
    logic [16:0]   cnt;
    logic [5:0]    hreq;
    logic [5:0]    sreq;
    logic          hard_oe;
    logic          soft_oe;
    logic          cfg_oe;
    logic          int_rst;
    logic [2:0]    rsrc;
    logic          div;
    logic          lock_err;
    logic [9:0]    hard_age;
    logic [9:0]    soft_age;
    logic [4:0]    gap;
  } seq_reg_type;

endpackage : reset_init_pkg

// ==== hdl/pin_sync.sv ====
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to sys_clk_in
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             srst_in,
  input  wire logic [WIDTH-1:0] rst_val_in,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      meta_q <= rst_val_in;
      sync_q <= rst_val_in;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : pin_sync

// ==== verification/board_supervisor.sv ====
// Purpose: board reset supervisor and strap model
// Assumes: reset lines pulled up, straps always fitted
// Notes:   tasks are called by the bench at falling edges
`timescale 1ns/1ps
module board_supervisor (
  // clock
  input  wire logic       sys_clk_in,
  // device drive
  input  wire logic       hard_oe_in,
  input  wire logic       soft_oe_in,
  input  wire logic       cfg_oe_in,
  input  wire logic [2:0] dev_rsrc_in,
  input  wire logic       dev_div_in,
  // board lines
  output logic            por_n_out,
  output logic            hard_n_out,
  output logic            soft_n_out,
  output logic [2:0]      rsrc_out,
  output logic            div_out,
  output logic            pll_lock_out,
  output logic            dll_lock_out
);
  logic       hard_pull;
  logic       soft_pull;
  logic [2:0] strap_rsrc;
  logic       strap_div;
  // open drain lines, pulled high
  assign hard_n_out = !(hard_oe_in || hard_pull);
  assign soft_n_out = !(soft_oe_in || soft_pull);
  // straps hold until the device drives back
  assign rsrc_out = cfg_oe_in ? dev_rsrc_in : strap_rsrc;
  assign div_out  = cfg_oe_in ? dev_div_in : strap_div;
  initial begin
    {por_n_out, hard_pull, soft_pull, pll_lock_out} = 4'h0;
    {dll_lock_out, strap_rsrc, strap_div} = 5'h0;
  end
  // pull one reset line low for n cycles
  task automatic pin_pulse(input bit hard, input int n);
    @(negedge sys_clk_in);
    hard_pull = hard;
    soft_pull = !hard;
    repeat (n) @(negedge sys_clk_in);
    hard_pull = 1'b0;
    soft_pull = 1'b0;
  endtask : pin_pulse
  // power-on reset and DLL lock, straps, then PLL lock
  task automatic power_up(input logic [2:0] rs, input logic dv,
                          input bit pll_ok);
    @(negedge sys_clk_in);
    por_n_out    = 1'b0;
    pll_lock_out = 1'b0;
    dll_lock_out = 1'b1;
    strap_rsrc   = ~rs;
    strap_div    = ~dv;
    repeat (32) @(negedge sys_clk_in);
    strap_rsrc = rs;
    strap_div  = dv;
    repeat (4) @(negedge sys_clk_in);
    por_n_out = 1'b1;
    repeat (20) @(negedge sys_clk_in);
    pll_lock_out = pll_ok;
  endtask : power_up
endmodule : board_supervisor

// ==== verification/reset_init_sequencer_tb.sv ====
// Purpose: self-checking bench of the reset sequencer
// Assumes: short DLL counts, board model on the pins
// Notes:   notes queued by the driver, checked at soft release
`timescale 1ns/1ps
module reset_init_sequencer_tb;
  import reset_init_pkg::*;
  typedef struct {
    bit         gap_on;
    int         len_lo;
    int         len_hi;
    int         lat_lo;
    logic [5:0] bits;
  } note_type;
  logic       clk, srst, por_n, hard_n, hard_oe, soft_n, soft_oe;
  logic       cfg_oe, div_w, div_q, pll, dll, irst, tmo, hard_p, soft_p;
  logic       hard_o, soft_o;
  logic [2:0] rsrc_w, rsrc_q;
  int         n_fail, total_checks, cycles;
  int         hard_age, hard_len, soft_len, lat;
  note_type   notes[$];

  reset_init_sequencer #(.DLL_MIN_CYC(17'h8), .DLL_MAX_CYC(17'h40))
  i_reset_init_sequencer (.sys_clk_in(clk), .srst_in(srst),
    .power_on_reset_n_in(por_n), .hard_reset_n_in(hard_n),
    .hard_reset_n_out(hard_o), .hard_reset_n_oe_out(hard_oe),
    .soft_reset_n_in(soft_n), .soft_reset_n_out(soft_o),
    .soft_reset_n_oe_out(soft_oe), .reset_source_cfg_in(rsrc_w),
    .reset_source_cfg_out(rsrc_q), .input_clock_div_cfg_in(div_w),
    .input_clock_div_cfg_out(div_q), .cfg_oe_out(cfg_oe),
    .pll_lock_in(pll), .dll_lock_in(dll), .internal_reset_out(irst),
    .lock_timeout_out(tmo));
  board_supervisor i_board_supervisor (.sys_clk_in(clk),
    .hard_oe_in(hard_oe), .soft_oe_in(soft_oe), .cfg_oe_in(cfg_oe),
    .dev_rsrc_in(rsrc_q), .dev_div_in(div_q), .por_n_out(por_n),
    .hard_n_out(hard_n), .soft_n_out(soft_n), .rsrc_out(rsrc_w),
    .div_out(div_w), .pll_lock_out(pll), .dll_lock_out(dll));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ------------------------------------------------------------
  // compares and closing
  // ------------------------------------------------------------
  task automatic chk_bits(input logic [5:0] got, input logic [5:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t outputs %b expected %b", $time, got, exp);
    end
  endtask : chk_bits
  task automatic chk_range(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("[FAIL] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_range
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  task automatic drain;
    for (int i = 0; i < 3000 && notes.size() > 0; i++) @(negedge clk);
    repeat (4) @(negedge clk);
  endtask : drain
  // ------------------------------------------------------------
  // output watcher
  // ------------------------------------------------------------
  always @(posedge clk) begin : mon
    note_type nt;
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      $display("[FAIL] %0t run too long", $time);
      close_out();
    end else if (srst === 1'b1) begin
      {hard_p, soft_p} = 2'b11;
      hard_len = 0;
      soft_len = 0;
      hard_age = 99;
    end else begin
      lat = (por_n === 1'b1) ? lat + 1 : 0;
      hard_age++;
      if (hard_oe === 1'b1 && hard_p !== 1'b1) begin
        hard_len = 0;
        chk_bits({5'h0, cfg_oe}, 6'h0);
        chk_bits({2'h0, hard_o, soft_o, soft_oe, irst}, 6'h3);
      end
      if (soft_oe === 1'b1 && soft_p !== 1'b1) soft_len = 0;
      if (hard_oe === 1'b0 && hard_p === 1'b1) begin
        hard_age = 0;
        chk_range(hard_len, 512, 1 << 20);
        chk_bits({5'h0, cfg_oe}, 6'h0);
      end
      if (hard_age == 1) chk_bits({5'h0, cfg_oe}, 6'h1);
      if (soft_oe === 1'b0 && soft_p === 1'b1) begin
        if (notes.size() == 0) begin
          n_fail++;
          $display("[FAIL] %0t unexpected soft release", $time);
        end else begin
          nt = notes.pop_front();
          chk_range(soft_len, nt.len_lo, nt.len_hi);
          chk_range(lat, nt.lat_lo, 1 << 30);
          if (nt.gap_on) begin
            chk_range(hard_age, 16, 16);
            chk_bits({rsrc_q, div_q, tmo, irst}, nt.bits);
          end
        end
      end
      hard_len += int'(hard_oe === 1'b1);
      soft_len += int'(soft_oe === 1'b1);
      hard_p = hard_oe;
      soft_p = soft_oe;
    end
  end
  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  initial begin
    logic [2:0] rs;
    logic       dv;
    bit         ok;
    srst = 1'b1;
    void'($urandom(32'h0c4e));
    repeat (2) @(negedge clk);
    srst = 1'b0;
    for (int k = 0; k < 3; k++) begin
      rs = 3'($urandom());
      dv = 1'($urandom());
      ok = (k != 1);
      notes.push_back('{1'b1, 528, 1 << 20, ok ? 550 : 1520,
                        {rs, dv, !ok, 1'b0}});
      i_board_supervisor.power_up(rs, dv, ok);
      drain();
    end
    notes.push_back('{1'b1, 528, 1 << 20, 0, {rs, dv, 2'b00}});
    i_board_supervisor.pin_pulse(1'b1, 34 + 3'($urandom()));
    drain();
    notes.push_back('{1'b0, 512, 514, 0, 6'h0});
    i_board_supervisor.pin_pulse(1'b0, 40);
    drain();
    i_board_supervisor.pin_pulse(1'b1, 20);
    repeat (40) @(negedge clk);
    chk_bits({5'h0, hard_oe}, 6'h0);
    repeat (660) @(negedge clk);
    chk_bits({5'h0, hard_oe}, 6'h0);
    chk_range(notes.size(), 0, 0);
    close_out();
  end
endmodule : reset_init_sequencer_tb
